// File: core/jip_pkg.sv
// Constants, types and layouts for the serial configuration port
// How it works
// - After power-up all four test pins are inputs awaiting host commands.
// - Data out pin is driven only after the channel-enabling command.
// - The enabling command may also switch on status and error outputs.
// - Configuration instructions accepted; no boundary-scan operation.
// - Blank part uses four port C pins as basic test signals.
// - Mode bit0, clock bit1, status bit3, error bit4, in bit5, out bit6.
// - Serial port programs both flash arrays, logic and configuration bits; here it programs flash only, lock and protect are set over Wishbone.
// - Error output goes low on sector erase or byte program failure.
// - Error stays low until clear command or chip reset after disable.
// - Status output high in read mode.
// - Status output low during program, erase or secondary flash write.
// - Enabling command can select open-drain for both extension outputs.
// - Read lock set refuses every content read.
// - Read lock set allows only full chip erase; others blocked.
// - Full chip erase leaves part blank and unlocked.
// - Each sector has a protect bit rejecting its erase.
// - Chip reset aborts program or erase and returns to read mode.
// - Delivered state reads all ones in memory and logic.
package jip_pkg;
	localparam int CLK_MHZ = 200;
	localparam int PROG_TIME_NS = 10000;
	localparam int ERASE_TIME_NS = 100000;
	localparam int CHIP_ERASE_TIME_NS = 400000;
	localparam int PROG_CYC = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int ERASE_CYC = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int CHIP_ERASE_CYC = (CHIP_ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 24;

	// Flash: sectors 0..2 primary, last sector secondary
	localparam int MEM_DEPTH = 32;
	localparam int SECT_BYTES = 8;
	localparam int NSECT = MEM_DEPTH / SECT_BYTES;
	localparam int ADDR_W = 5;
	localparam int SECT_W = 2;
	localparam logic [7:0] BLANK_BYTE = 8'hFF;

	// Instruction register
	localparam int IR_W = 8;
	localparam logic [7:0] IR_CFG_ENABLE = 8'h01;
	localparam logic [7:0] IR_CFG_DISABLE = 8'h02;
	localparam logic [7:0] IR_ERR_CLEAR = 8'h03;
	localparam logic [7:0] IR_PROGRAM = 8'h10;
	localparam logic [7:0] IR_SECT_ERASE = 8'h11;
	localparam logic [7:0] IR_CHIP_ERASE = 8'h12;
	localparam logic [7:0] IR_READ = 8'h13;
	localparam logic [7:0] IR_STATUS = 8'h14;
	localparam logic [7:0] IR_BYPASS = 8'hFF;
	localparam logic [1:0] IR_CAPTURE = 2'h1;

	// Data register: address in high byte, data in low byte
	localparam int DR_W = 16;
	localparam int DR_ADDR_LSB = 8;
	localparam int EN_EXT_BIT = 0;
	localparam int EN_OD_BIT = 1;

	// Wishbone register map
	localparam logic [7:0] REG_LOCK = 8'h00;
	localparam logic [7:0] REG_PROTECT = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int ST_BUSY = 0;
	localparam int ST_ERR = 1;
	localparam int ST_CHAN = 2;
	localparam int ST_EXT = 3;
	localparam int ST_OD = 4;
	localparam int ST_LOCK = 5;

	typedef enum logic [3:0] {
		TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SHIFT_DR, TS_EXIT1_DR,
		TS_PAUSE_DR, TS_EXIT2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SHIFT_IR,
		TS_EXIT1_IR, TS_PAUSE_IR, TS_EXIT2_IR, TS_UPD_IR
	} jip_tap_t;

	typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_SECT, OP_CHIP} jip_op_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} jip_wb_req_t;

	typedef struct packed {
		logic [2:0] tck_s;
		logic [1:0] tms_s;
		logic [1:0] tdi_s;
		logic [2:0] rst_s;
		jip_tap_t tap;
		logic [IR_W-1:0] ir_sh;
		logic [IR_W-1:0] ir;
		logic [DR_W-1:0] dr_sh;
		logic [ADDR_W-1:0] rd_addr;
		logic chan_en;
		logic ext_en;
		logic od_sel;
		logic disabled;
		logic err;
		logic lock;
		logic [NSECT-1:0] protect;
		jip_op_t op;
		logic [CNT_W-1:0] cnt;
		logic [ADDR_W-1:0] op_addr;
		logic [7:0] op_data;
		logic [MEM_DEPTH-1:0][7:0] mem;
		logic tdo;
		logic tdo_oe;
		logic stat_o;
		logic stat_oe;
		logic err_o;
		logic err_oe;
		logic ack;
		logic [31:0] rdat;
	} jip_state_t;
endpackage : jip_pkg

// File: core/jip_port.sv
// Serial in-system configuration port with flash model and Wishbone control
`timescale 1ns/1ps
module jip_port
	import jip_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int CHIP_ERASE_CYCLES = CHIP_ERASE_CYC
)(
	// System
	input wire logic clk_sys,
	input wire logic rstn,
	// Wishbone slave
	input wire jip_wb_req_t wb_req,
	output logic wb_ack,
	output logic [31:0] wb_dat_o,
	// Chip reset pin, active low
	input wire logic chip_rst_n,
	// Test pins on port C
	input wire logic port_c_bit0,
	input wire logic port_c_bit1,
	input wire logic port_c_bit5,
	output logic port_c_bit6_o,
	output logic port_c_bit6_oe,
	output logic port_c_bit3_o,
	output logic port_c_bit3_oe,
	output logic port_c_bit4_o,
	output logic port_c_bit4_oe
);
	jip_state_t s_r;
	jip_state_t s_nxt;

	function automatic jip_tap_t tap_next(input jip_tap_t t, input logic tms);
		case (t)
			TS_RESET: tap_next = tms ? TS_RESET : TS_IDLE;
			TS_IDLE: tap_next = tms ? TS_SEL_DR : TS_IDLE;
			TS_SEL_DR: tap_next = tms ? TS_SEL_IR : TS_CAP_DR;
			TS_CAP_DR: tap_next = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
			TS_SHIFT_DR: tap_next = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
			TS_EXIT1_DR: tap_next = tms ? TS_UPD_DR : TS_PAUSE_DR;
			TS_PAUSE_DR: tap_next = tms ? TS_EXIT2_DR : TS_PAUSE_DR;
			TS_EXIT2_DR: tap_next = tms ? TS_UPD_DR : TS_SHIFT_DR;
			TS_UPD_DR: tap_next = tms ? TS_SEL_DR : TS_IDLE;
			TS_SEL_IR: tap_next = tms ? TS_RESET : TS_CAP_IR;
			TS_CAP_IR: tap_next = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
			TS_SHIFT_IR: tap_next = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
			TS_EXIT1_IR: tap_next = tms ? TS_UPD_IR : TS_PAUSE_IR;
			TS_PAUSE_IR: tap_next = tms ? TS_EXIT2_IR : TS_PAUSE_IR;
			TS_EXIT2_IR: tap_next = tms ? TS_UPD_IR : TS_SHIFT_IR;
			TS_UPD_IR: tap_next = tms ? TS_SEL_DR : TS_IDLE;
			default: tap_next = TS_RESET;
		endcase
	endfunction : tap_next

	function automatic logic [SECT_W-1:0] sect_of(input logic [ADDR_W-1:0] a);
		sect_of = a[ADDR_W-1 -: SECT_W];
	endfunction : sect_of

	function automatic logic dr_is_long(input logic [IR_W-1:0] code);
		// Codes without a 16-bit register fall back to the one-bit bypass
		case (code)
			IR_CFG_ENABLE, IR_PROGRAM, IR_SECT_ERASE, IR_READ, IR_STATUS: dr_is_long = 1'b1;
			default: dr_is_long = 1'b0;
		endcase
	endfunction : dr_is_long

	function automatic logic may_start(input logic locked, input logic running);
		// Only the full erase may start on a locked part
		may_start = ~locked & ~running;
	endfunction : may_start

	function automatic logic [1:0] pin_drive(input logic level, input logic ext,
		input logic od);
		// Open drain only pulls low, so the enable follows a low level
		pin_drive[1] = od ? 1'b0 : level;
		pin_drive[0] = ext & (~od | ~level);
	endfunction : pin_drive

	logic tck_rise;
	logic tck_fall;
	logic tms;
	logic tdi;
	logic chip_rst;
	logic busy;
	logic err_set;
	logic err_clr;
	logic [ADDR_W-1:0] dr_addr;
	logic wb_hit;
	logic [31:0] rd_word;

	always_comb
	begin
		s_nxt = s_r;
		// Edge detect only on synchronised copies, never on the first stage
		// Two stages for metastability, a third to find the edge
		s_nxt.tck_s = {s_r.tck_s[1:0], port_c_bit1};
		s_nxt.tms_s = {s_r.tms_s[0], port_c_bit0};
		s_nxt.tdi_s = {s_r.tdi_s[0], port_c_bit5};
		s_nxt.rst_s = {s_r.rst_s[1:0], ~chip_rst_n};
		tck_rise = s_r.tck_s[1] & ~s_r.tck_s[2];
		tck_fall = ~s_r.tck_s[1] & s_r.tck_s[2];
		tms = s_r.tms_s[1];
		tdi = s_r.tdi_s[1];
		chip_rst = s_r.rst_s[1] & ~s_r.rst_s[2];
		busy = (s_r.op != OP_NONE);
		dr_addr = s_r.dr_sh[DR_ADDR_LSB +: ADDR_W];
		err_set = 1'b0;
		err_clr = 1'b0;

		// Test access port, stepped on sampled clock rises
		if (tck_rise)
		begin
			s_nxt.tap = tap_next(s_r.tap, tms);
			case (s_r.tap)
				TS_RESET:
				begin
					s_nxt.ir = IR_BYPASS;
				end
				TS_CAP_IR:
				begin
					s_nxt.ir_sh = {6'h00, IR_CAPTURE};
				end
				TS_SHIFT_IR:
				begin
					s_nxt.ir_sh = {tdi, s_r.ir_sh[IR_W-1:1]};
				end
				TS_UPD_IR:
				begin
					// No boundary-scan register: unknown codes act as bypass
					s_nxt.ir = s_r.ir_sh;
					case (s_r.ir_sh)
						IR_CFG_DISABLE:
						begin
							s_nxt.chan_en = 1'b0;
							s_nxt.ext_en = 1'b0;
							s_nxt.disabled = 1'b1;
						end
						IR_ERR_CLEAR:
						begin
							err_clr = 1'b1;
						end
						IR_CHIP_ERASE:
						begin
							// Allowed even when locked
							if (!busy)
							begin
								s_nxt.op = OP_CHIP;
								s_nxt.cnt = CNT_W'(CHIP_ERASE_CYCLES);
							end
						end
						default:
						begin
						end
					endcase
				end
				TS_CAP_DR:
				begin
					case (s_r.ir)
						IR_READ:
						begin
							// Locked part reads back zero
							s_nxt.dr_sh = {{(8-ADDR_W){1'b0}}, s_r.rd_addr,
								s_r.lock ? 8'h00 : s_r.mem[s_r.rd_addr]};
						end
						IR_STATUS:
						begin
							s_nxt.dr_sh = {10'h000, s_r.lock, s_r.od_sel, s_r.ext_en,
								s_r.chan_en, s_r.err, busy};
						end
						default:
						begin
							s_nxt.dr_sh = '0;
						end
					endcase
				end
				TS_SHIFT_DR:
				begin
					if (dr_is_long(s_r.ir))
					begin
						s_nxt.dr_sh = {tdi, s_r.dr_sh[DR_W-1:1]};
					end
					else
					begin
						s_nxt.dr_sh = {{(DR_W-1){1'b0}}, tdi};
					end
				end
				TS_UPD_DR:
				begin
					case (s_r.ir)
						IR_CFG_ENABLE:
						begin
							s_nxt.chan_en = 1'b1;
							s_nxt.ext_en = s_r.dr_sh[EN_EXT_BIT];
							s_nxt.od_sel = s_r.dr_sh[EN_OD_BIT];
							s_nxt.disabled = 1'b0;
						end
						IR_READ:
						begin
							s_nxt.rd_addr = dr_addr;
						end
						IR_PROGRAM:
						begin
							// Blocked while locked or busy
							if (may_start(s_r.lock, busy))
							begin
								if ((s_r.mem[dr_addr] & s_r.dr_sh[7:0]) != s_r.dr_sh[7:0])
								begin
									err_set = 1'b1;
								end
								else
								begin
									s_nxt.op = OP_PROG;
									s_nxt.cnt = CNT_W'(PROG_CYCLES);
									s_nxt.op_addr = dr_addr;
									s_nxt.op_data = s_r.dr_sh[7:0];
								end
							end
						end
						IR_SECT_ERASE:
						begin
							if (may_start(s_r.lock, busy))
							begin
								if (s_r.protect[sect_of(dr_addr)])
								begin
									err_set = 1'b1;
								end
								else
								begin
									s_nxt.op = OP_SECT;
									s_nxt.cnt = CNT_W'(ERASE_CYCLES);
									s_nxt.op_addr = dr_addr;
								end
							end
						end
						default:
						begin
						end
					endcase
				end
				default:
				begin
				end
			endcase
		end

		// Data out changes on the sampled falling edge
		if (tck_fall)
		begin
			s_nxt.tdo = (s_r.tap == TS_SHIFT_IR) ? s_r.ir_sh[0] : s_r.dr_sh[0];
		end

		// Flash cycle timer and completion
		// Memory changes only when the timer runs out, so an abort leaves it intact
		if (busy)
		begin
			if (s_r.cnt > CNT_W'(1))
			begin
				s_nxt.cnt = s_r.cnt - CNT_W'(1);
			end
			else
			begin
				s_nxt.op = OP_NONE;
				case (s_r.op)
					OP_PROG:
					begin
						s_nxt.mem[s_r.op_addr] = s_r.mem[s_r.op_addr] & s_r.op_data;
					end
					OP_SECT:
					begin
						for (int i = 0; i < MEM_DEPTH; i++)
						begin
							if (i / SECT_BYTES == int'(sect_of(s_r.op_addr)))
							begin
								s_nxt.mem[i] = BLANK_BYTE;
							end
						end
					end
					OP_CHIP:
					begin
						for (int i = 0; i < MEM_DEPTH; i++)
						begin
							s_nxt.mem[i] = BLANK_BYTE;
						end
						s_nxt.lock = 1'b0;
						s_nxt.protect = '0;
					end
					default:
					begin
					end
				endcase
			end
		end

		// Chip reset aborts any cycle at once, back to read mode
		// Asserting edge only: a reset held through programming leaves cycles running
		if (chip_rst)
		begin
			s_nxt.op = OP_NONE;
			s_nxt.cnt = '0;
			if (s_r.disabled)
			begin
				err_clr = 1'b1;
			end
		end

		// Set wins over a clear in the same cycle
		s_nxt.err = err_set | (s_r.err & ~err_clr);

		// Wishbone slave: one wait state, ack drops the cycle after
		wb_hit = wb_req.cyc & wb_req.stb & ~s_r.ack;
		rd_word = '0;
		case (wb_req.adr)
			REG_LOCK: rd_word[0] = s_r.lock;
			REG_PROTECT: rd_word[NSECT-1:0] = s_r.protect;
			REG_STATUS:
			begin
				rd_word[ST_BUSY] = busy;
				rd_word[ST_ERR] = s_r.err;
				rd_word[ST_CHAN] = s_r.chan_en;
				rd_word[ST_EXT] = s_r.ext_en;
				rd_word[ST_OD] = s_r.od_sel;
				rd_word[ST_LOCK] = s_r.lock;
			end
			default: rd_word = '0;
		endcase
		s_nxt.ack = wb_hit;
		// Read data is zero outside the ack cycle
		s_nxt.rdat = wb_hit ? rd_word : '0;
		if (wb_hit && wb_req.we && wb_req.sel[0])
		begin
			// Lock can only be set here; only a chip erase removes it
			if (wb_req.adr == REG_LOCK && wb_req.dat[0])
			begin
				s_nxt.lock = 1'b1;
			end
			if (wb_req.adr == REG_PROTECT)
			begin
				s_nxt.protect = wb_req.dat[NSECT-1:0];
			end
		end

		// Pin drivers, all registered
		s_nxt.tdo_oe = s_nxt.chan_en;
		// Status high in read mode, low while any cycle runs
		{s_nxt.stat_o, s_nxt.stat_oe} = pin_drive(s_nxt.op == OP_NONE, s_nxt.ext_en,
			s_nxt.od_sel);
		{s_nxt.err_o, s_nxt.err_oe} = pin_drive(~s_nxt.err, s_nxt.ext_en,
			s_nxt.od_sel);
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			s_r <= '0;
			s_r.tap <= TS_RESET;
			s_r.ir <= IR_BYPASS;
			// Delivered state: memory reads as all ones
			s_r.mem <= {MEM_DEPTH{BLANK_BYTE}};
			s_r.stat_o <= 1'b1;
			s_r.err_o <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign wb_ack = s_r.ack;
	assign wb_dat_o = s_r.rdat;
	assign port_c_bit6_o = s_r.tdo;
	assign port_c_bit6_oe = s_r.tdo_oe;
	assign port_c_bit3_o = s_r.stat_o;
	assign port_c_bit3_oe = s_r.stat_oe;
	assign port_c_bit4_o = s_r.err_o;
	assign port_c_bit4_oe = s_r.err_oe;
endmodule : jip_port

// File: testbench/jip_jtag_host.sv
// Test-port host model driving clock, mode select and data in
`timescale 1ns/1ps
module jip_jtag_host (
	// Sampling clock of the block
	input wire logic clk_sys,
	// Link pins
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// Clock stands low between frames
	// Eight system clocks per half period give the 80 ns link clock
	task automatic step(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		repeat (8) @(posedge clk_sys);
		tck <= 1'b1;
		q = tdo;
		repeat (8) @(posedge clk_sys);
		tck <= 1'b0;
	endtask : step
	task automatic scan(input logic is_ir, input int n, input logic [15:0] v,
		output logic [15:0] q);
		logic b;
		q = '0;
		step(1'b1, 1'b0, b);
		if (is_ir)
			step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
		step(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++)
			step(i == n - 1, v[i], q[i]);
		step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
	endtask : scan
endmodule : jip_jtag_host

// File: testbench/jip_port_assertions.sv
// Port-level assertions for the serial configuration port
`timescale 1ns/1ps
module jip_port_assertions
	import jip_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int CHIP_ERASE_CYCLES = CHIP_ERASE_CYC
)(
	// System
	input wire logic clk_sys,
	input wire logic rstn,
	// Bus
	input wire jip_wb_req_t wb_req,
	input wire logic wb_ack,
	input wire logic [31:0] wb_dat_o,
	// Pins
	input wire logic chip_rst_n,
	input wire logic port_c_bit1,
	input wire logic port_c_bit6_o,
	input wire logic port_c_bit6_oe,
	input wire logic port_c_bit3_o,
	input wire logic port_c_bit3_oe,
	input wire logic port_c_bit4_oe
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	logic busy;
	logic [23:0] busy_cnt_r;
	assign busy = port_c_bit3_oe && !port_c_bit3_o;
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			busy_cnt_r <= '0;
		else
			busy_cnt_r <= busy ? busy_cnt_r + 24'h1 : '0;
	sequence s_req;
		wb_req.cyc && wb_req.stb && !wb_ack;
	endsequence
	sequence s_rst_edge;
		$fell(chip_rst_n);
	endsequence
	a_ack_latency: assert property (s_req |=> wb_ack)
		else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack |=> !wb_ack)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack |-> $past(wb_req.cyc && wb_req.stb))
		else $error("ack without request");
	a_dat_idle: assert property (!wb_ack |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_unmapped_zero: assert property (s_req ##0 (wb_req.adr > REG_STATUS)
		|=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_pins_boot: assert property ($rose(rstn) |->
		!port_c_bit6_oe && !port_c_bit3_oe && !port_c_bit4_oe)
		else $error("pin driven after reset");
	a_abort_reset: assert property (s_rst_edge |-> ##3 !busy)
		else $error("flash cycle survives chip reset");
	a_tdo_on_fall: assert property ($changed(port_c_bit6_o) |-> !$past(port_c_bit1))
		else $error("data out changed while clock high");
	a_busy_bounded: assert property (int'(busy_cnt_r) <= CHIP_ERASE_CYCLES + 4)
		else $error("status low too long");
endmodule : jip_port_assertions
bind jip_port jip_port_assertions #(
	.PROG_CYCLES(PROG_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES),
	.CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES)
) u_jip_port_assertions (
	.clk_sys(clk_sys), .rstn(rstn), .wb_req(wb_req), .wb_ack(wb_ack),
	.wb_dat_o(wb_dat_o), .chip_rst_n(chip_rst_n), .port_c_bit1(port_c_bit1),
	.port_c_bit6_o(port_c_bit6_o), .port_c_bit6_oe(port_c_bit6_oe),
	.port_c_bit3_o(port_c_bit3_o), .port_c_bit3_oe(port_c_bit3_oe),
	.port_c_bit4_oe(port_c_bit4_oe)
);

// File: testbench/jip_port_tb_top.sv
// Self-checking bench for the serial configuration port
`timescale 1ns/1ps
module jip_port_tb_top
	import jip_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic chip_rst_n = 1'b0;
	jip_wb_req_t wb_req = '0;
	logic wb_ack;
	logic [31:0] wb_dat_o;
	logic tck, tms, tdi, tdo_w, stat_w, err_w;
	logic tdo_last = 1'b0;
	logic p6, p6e, p3, p3e, p4, p4e;
	logic saw_busy = 1'b0;
	logic [31:0] seed = 32'h45706E17;
	logic [31:0] q;
	logic [15:0] jq;
	logic [7:0] exp_mem [MEM_DEPTH];
	int err_count = 0;
	int n_tests = 0;
	always #2.5 clk_sys = ~clk_sys;
	jip_port #(.PROG_CYCLES(20), .ERASE_CYCLES(40), .CHIP_ERASE_CYCLES(60)) u_jip_port (
		.clk_sys(clk_sys), .rstn(rstn), .wb_req(wb_req), .wb_ack(wb_ack),
		.wb_dat_o(wb_dat_o), .chip_rst_n(chip_rst_n), .port_c_bit0(tms),
		.port_c_bit1(tck), .port_c_bit5(tdi), .port_c_bit6_o(p6), .port_c_bit6_oe(p6e),
		.port_c_bit3_o(p3), .port_c_bit3_oe(p3e), .port_c_bit4_o(p4), .port_c_bit4_oe(p4e)
	);
	jip_jtag_host u_host (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));
	// Released data line shows the inverse of its last level
	always @(posedge clk_sys)
		if (p6e)
			tdo_last <= p6;
	assign tdo_w = p6e ? p6 : ~tdo_last;
	assign stat_w = p3e ? p3 : 1'b1;
	assign err_w = p4e ? p4 : 1'b1;
	always @(posedge clk_sys)
		if (stat_w === 1'b0)
			saw_busy <= 1'b1;
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		@(posedge clk_sys);
		while (wb_ack !== 1'b1)
			@(posedge clk_sys);
		q = wb_dat_o;
		wb_req <= '0;
	endtask : wb
	task automatic jcmd(input logic [7:0] ir, input logic [15:0] dr, input int n);
		u_host.scan(1'b1, IR_W, {8'h00, ir}, jq);
		if (n > 0)
			u_host.scan(1'b0, n, dr, jq);
	endtask : jcmd
	task automatic jrd(input logic [4:0] a);
		jcmd(IR_READ, {3'h0, a, 8'h00}, DR_W);
		u_host.scan(1'b0, DR_W, 16'h0, jq);
	endtask : jrd
	task automatic wait_ready();
		repeat (3) @(posedge clk_sys);
		for (int i = 0; i < 300 && stat_w !== 1'b1; i++)
			@(posedge clk_sys);
	endtask : wait_ready
	task automatic prog(input logic [4:0] a, input logic [7:0] d);
		logic bad;
		bad = (exp_mem[a] & d) != d;
		saw_busy = 1'b0;
		jcmd(IR_PROGRAM, {3'h0, a, d}, DR_W);
		wait_ready();
		chk(saw_busy, !bad);
		chk(err_w, !bad);
		if (!bad)
			exp_mem[a] = d;
		jrd(a);
		chk(jq[7:0], exp_mem[a]);
		if (bad)
			jcmd(IR_ERR_CLEAR, 16'h0, 0);
		chk(err_w, 1'b1);
	endtask : prog
	// Brief release, then a fresh assertion: the abort keys on that edge
	task automatic chip_pulse();
		@(posedge clk_sys);
		chip_rst_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		chip_rst_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : chip_pulse
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	initial
	begin
		#400000;
		err_count++;
		summarize();
	end
	initial
	begin
		for (int i = 0; i < MEM_DEPTH; i++)
			exp_mem[i] = BLANK_BYTE;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		wb(1'b0, REG_STATUS, 32'h0);
		chk(q, 32'h0);
		wb(1'b0, 8'h0C, 32'h0);
		chk(q, 32'h0);
		u_host.step(1'b0, 1'b0, jq[0]);
		jcmd(IR_STATUS, 16'h0, DR_W);
		chk(p6e, 1'b0);
		jcmd(IR_CFG_ENABLE, 16'h0001, DR_W);
		chk({p6e, p3e, p4e, stat_w, err_w}, 5'h1F);
		repeat (6)
		begin
			seed = lfsr_next(seed);
			prog(seed[12:8], seed[7:0]);
		end
		prog(5'h1F, 8'h0F);
		prog(5'h1F, 8'hF0);
		wb(1'b1, REG_PROTECT, 32'h2);
		wb(1'b0, REG_PROTECT, 32'h0);
		chk(q, 32'h2);
		jcmd(IR_SECT_ERASE, 16'h0800, DR_W);
		wait_ready();
		chk(err_w, 1'b0);
		jcmd(IR_ERR_CLEAR, 16'h0, 0);
		chk(err_w, 1'b1);
		saw_busy = 1'b0;
		jcmd(IR_SECT_ERASE, 16'h0300, DR_W);
		wait_ready();
		chk(saw_busy, 1'b1);
		jrd(5'h2);
		chk(jq[7:0], BLANK_BYTE);
		prog(5'h12, 8'h00);
		jcmd(IR_SECT_ERASE, 16'h1200, DR_W);
		chip_pulse();
		chk(stat_w, 1'b1);
		jrd(5'h12);
		chk(jq[7:0], 8'h00);
		jcmd(IR_PROGRAM, 16'h12FF, DR_W);
		chk(err_w, 1'b0);
		jcmd(IR_CFG_DISABLE, 16'h0, 0);
		chk(p6e, 1'b0);
		chip_pulse();
		wb(1'b0, REG_STATUS, 32'h0);
		chk(q, 32'h0);
		jcmd(IR_CFG_ENABLE, 16'h0003, DR_W);
		chk({p6e, p3e, p4e}, 3'h4);
		wb(1'b1, REG_LOCK, 32'h1);
		wb(1'b1, REG_LOCK, 32'h0);
		wb(1'b0, REG_STATUS, 32'h0);
		chk(q, 32'h3C);
		jrd(5'h2);
		chk(jq[7:0], 8'h00);
		saw_busy = 1'b0;
		jcmd(IR_SECT_ERASE, 16'h1200, DR_W);
		jcmd(IR_PROGRAM, 16'h0200, DR_W);
		wait_ready();
		chk(saw_busy, 1'b0);
		jcmd(IR_CHIP_ERASE, 16'h0, 0);
		wait_ready();
		chk(saw_busy, 1'b1);
		wb(1'b0, REG_STATUS, 32'h0);
		chk(q, 32'h1C);
		jrd(5'h12);
		chk(jq[7:0], BLANK_BYTE);
		summarize();
	end
endmodule : jip_port_tb_top
